// File: hw/cfis_pkg.sv
package cfis_pkg;

  // program counter width and reset point, stack pointer reset point and push step
  localparam int          PC_W          = 10;
  localparam logic [11:0] PC_RESET      = 12'hC00;
  localparam logic [7:0]  SP_RESET      = 8'h3F;
  localparam logic [7:0]  SP_STEP       = 8'h02;

  // interrupt vectors, one per source
  localparam logic [11:0] VEC_WAKE      = 12'hFFA;
  localparam logic [11:0] VEC_WDOG      = 12'hFF6;
  localparam logic [11:0] VEC_MTMR      = 12'hFF8;
  localparam logic [11:0] VEC_SOFT      = 12'hFFC;

  // request bit positions, lowest priority at the top
  localparam int          IRQ_SOFT      = 0;
  localparam int          IRQ_MTMR      = 1;
  localparam int          IRQ_WDOG      = 2;
  localparam int          IRQ_WAKE      = 3;
  localparam int          IRQ_N         = 4;

  // entry sequence length in cycles
  localparam logic [2:0]  ENTRY_CYCLES  = 3'h5;

  // status register bit positions
  localparam int          SR_C          = 0;
  localparam int          SR_H          = 1;
  localparam int          SR_Z          = 2;
  localparam int          SR_N          = 3;
  localparam int          SR_G          = 4;

  // register map, byte addresses
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_PC        = 8'h08;
  localparam logic [7:0]  REG_SP        = 8'h0C;
  localparam logic [7:0]  REG_RESULT    = 8'h10;
  localparam logic [7:0]  REG_ADDR      = 8'h14;
  localparam logic [7:0]  REG_TIMING    = 8'h18;
  localparam logic [7:0]  REG_INDEX     = 8'h1C;

  // operand addressing modes, one-hot
  typedef enum logic [6:0] {
    CFIS_AM_INDEXED   = 7'h01,
    CFIS_AM_INDIRECT  = 7'h02,
    CFIS_AM_DIRECT    = 7'h04,
    CFIS_AM_IMMEDIATE = 7'h08,
    CFIS_AM_INHERENT  = 7'h10,
    CFIS_AM_ABSOLUTE  = 7'h20,
    CFIS_AM_RELATIVE  = 7'h40
  } cfis_mode_t;

  // instruction classes driven by software through the control register
  typedef enum logic [3:0] {
    CFIS_OP_ALU       = 4'h0,
    CFIS_OP_LOAD      = 4'h1,
    CFIS_OP_STORE     = 4'h2,
    CFIS_OP_CMPX      = 4'h3,
    CFIS_OP_FAR_JUMP  = 4'h4,
    CFIS_OP_CALL_ABS  = 4'h5,
    CFIS_OP_SHORT_BR  = 4'h6,
    CFIS_OP_BITMAN    = 4'h7,
    CFIS_OP_SUB_EXIT  = 4'h8,
    CFIS_OP_IRQ_EXIT  = 4'h9,
    CFIS_OP_SOFT_IRQ  = 4'hA,
    CFIS_OP_SET_G     = 4'hB
  } cfis_op_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0]      sp;
    logic [7:0]      sr;
  } cfis_arch_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [2:0] cycles;
    logic       legal;
  } cfis_timing_t;

endpackage : cfis_pkg

// File: hw/cfis_irq_arb.sv
module cfis_irq_arb
(
  input  wire logic [cfis_pkg::IRQ_N-1:0] pend,
  input  wire logic                       g_bit,
  output logic                            take,
  output logic [cfis_pkg::IRQ_N-1:0]      grant,
  output logic [11:0]                     vector
);

  logic [cfis_pkg::IRQ_N-1:0] elig;

  always_comb
  begin
    elig                     = pend;
    elig[cfis_pkg::IRQ_WAKE] = pend[cfis_pkg::IRQ_WAKE] & g_bit;
    elig[cfis_pkg::IRQ_WDOG] = pend[cfis_pkg::IRQ_WDOG] & g_bit;
    elig[cfis_pkg::IRQ_MTMR] = pend[cfis_pkg::IRQ_MTMR] & g_bit;
    grant  = '0;
    vector = cfis_pkg::VEC_SOFT;
    if (elig[cfis_pkg::IRQ_WAKE])
    begin
      grant[cfis_pkg::IRQ_WAKE] = 1'b1;
      vector                    = cfis_pkg::VEC_WAKE;
    end
    else if (elig[cfis_pkg::IRQ_WDOG])
    begin
      grant[cfis_pkg::IRQ_WDOG] = 1'b1;
      vector                    = cfis_pkg::VEC_WDOG;
    end
    else if (elig[cfis_pkg::IRQ_MTMR])
    begin
      grant[cfis_pkg::IRQ_MTMR] = 1'b1;
      vector                    = cfis_pkg::VEC_MTMR;
    end
    else if (elig[cfis_pkg::IRQ_SOFT])
    begin
      grant[cfis_pkg::IRQ_SOFT] = 1'b1;
    end
    take = |elig;
  end

endmodule : cfis_irq_arb

// File: hw/cfis_timing.sv
module cfis_timing
(
  input  wire cfis_pkg::cfis_op_t   op,
  input  wire cfis_pkg::cfis_mode_t mode,
  output cfis_pkg::cfis_timing_t    tim
);

  always_comb
  begin
    tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
    case (op)
      cfis_pkg::CFIS_OP_ALU:
      begin
        if (mode == cfis_pkg::CFIS_AM_INDIRECT)
          tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
        else if (mode == cfis_pkg::CFIS_AM_DIRECT || mode == cfis_pkg::CFIS_AM_IMMEDIATE)
          tim = '{bytes: 2'h2, cycles: 3'h2, legal: 1'b1};
        else
          tim.legal = 1'b0;
      end
      cfis_pkg::CFIS_OP_LOAD:
      begin
        case (mode)
          cfis_pkg::CFIS_AM_INDEXED:   tim = '{bytes: 2'h2, cycles: 3'h3, legal: 1'b1};
          cfis_pkg::CFIS_AM_INDIRECT:  tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
          cfis_pkg::CFIS_AM_DIRECT:    tim = '{bytes: 2'h2, cycles: 3'h2, legal: 1'b1};
          cfis_pkg::CFIS_AM_IMMEDIATE: tim = '{bytes: 2'h2, cycles: 3'h2, legal: 1'b1};
          default:                     tim.legal = 1'b0;
        endcase
      end
      cfis_pkg::CFIS_OP_STORE:
      begin
        case (mode)
          cfis_pkg::CFIS_AM_INDEXED:  tim = '{bytes: 2'h2, cycles: 3'h3, legal: 1'b1};
          cfis_pkg::CFIS_AM_INDIRECT: tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
          cfis_pkg::CFIS_AM_DIRECT:   tim = '{bytes: 2'h2, cycles: 3'h2, legal: 1'b1};
          default:                    tim.legal = 1'b0;
        endcase
      end
      cfis_pkg::CFIS_OP_CMPX:
        tim = '{bytes: 2'h3, cycles: 3'h3, legal: mode == cfis_pkg::CFIS_AM_IMMEDIATE};
      cfis_pkg::CFIS_OP_FAR_JUMP:  tim = '{bytes: 2'h3, cycles: 3'h4, legal: 1'b1};
      cfis_pkg::CFIS_OP_CALL_ABS:  tim = '{bytes: 2'h3, cycles: 3'h5, legal: 1'b1};
      cfis_pkg::CFIS_OP_SHORT_BR:  tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
      cfis_pkg::CFIS_OP_BITMAN:    tim = '{bytes: 2'h2, cycles: 3'h2, legal: 1'b1};
      cfis_pkg::CFIS_OP_SUB_EXIT:  tim = '{bytes: 2'h1, cycles: 3'h5, legal: 1'b1};
      cfis_pkg::CFIS_OP_IRQ_EXIT:  tim = '{bytes: 2'h1, cycles: 3'h5, legal: 1'b1};
      cfis_pkg::CFIS_OP_SOFT_IRQ:  tim = '{bytes: 2'h1, cycles: 3'h5, legal: 1'b1};
      cfis_pkg::CFIS_OP_SET_G:     tim = '{bytes: 2'h1, cycles: 3'h1, legal: 1'b1};
      default:                     tim.legal = 1'b0;
    endcase
  end

endmodule : cfis_timing

// File: hw/cfis_core.sv
// Function
// - zero flag set when alu operand is zero
// - sign flag follows alu operand msb
// - masked sources pend but are not taken
// - mask clear at reset, software sets it
// - mask cleared after stacking and vector fetch
// - entry finishes instruction, stacks pc, five cycles
// - irq exit pops address, sets mask
// - four sources, software one never masked
// - software irq leaves mask; exit via subroutine
// - priority wake, watchdog, multifunction timer, software
// - indexed adds 8-bit offset to index
// - indirect uses index pointer as address
// - direct uses 8-bit address field
// - immediate uses 8-bit field as operand
// - far jump and call load pc field
// - short branch and bit ops add field
// - legal load, store, compare-index mode sets
// - bytes and cycles follow timing table
// - push decrements sp by two, low first
// - pc starts at 0x000 after reset, the low ten bits of 0xC00
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
module cfis_core
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  irq_src,
  output logic      [11:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  output logic             busy
);

  typedef enum logic [3:0] {
    CFIS_ST_IDLE  = 4'h1,
    CFIS_ST_EXEC  = 4'h2,
    CFIS_ST_ENTRY = 4'h4,
    CFIS_ST_POP   = 4'h8
  } cfis_state_t;

  localparam int PCW_HI = cfis_pkg::PC_W - 1;
  cfis_state_t            state_r;
  cfis_pkg::cfis_arch_t   arch_r;
  logic [11:0]            index_r;
  logic [7:0]             result_r;
  logic [11:0]            ea_r;
  logic [2:0]             cnt_r;
  logic [3:0]             pend_r;
  logic [3:0]             sync1_r;
  logic [3:0]             sync2_r;
  logic [3:0]             grant_r;
  logic [11:0]            vec_r;
  logic                   soft_r;
  logic                   set_g_pend_r;
  logic [PCW_HI:0]        ret_pc_r;
  logic [11:0]            mem_addr_r;
  logic [7:0]             mem_wdata_r;
  logic                   mem_we_r;
  logic [31:0]            hrdata_r;
  logic [7:0]             stk_r [0:255];

  // bus address phase capture
  logic                   dp_valid_r;
  logic                   dp_write_r;
  logic [7:0]             dp_addr_r;

  // command fields taken from the control write
  cfis_pkg::cfis_op_t     op_r;
  cfis_pkg::cfis_mode_t   mode_r;
  logic [7:0]             field_r;
  logic [9:0]             abs_r;
  logic [7:0]             alu_r;

  logic                   arb_take;
  logic [3:0]             arb_grant;
  logic [11:0]            arb_vec;
  cfis_pkg::cfis_timing_t tim;
  logic                   cmd_wr;
  logic                   boundary;

  cfis_irq_arb u_arb
  (
    .pend   (pend_r),
    .g_bit  (arch_r.sr[cfis_pkg::SR_G]),
    .take   (arb_take),
    .grant  (arb_grant),
    .vector (arb_vec)
  );

  cfis_timing u_tim
  (
    .op     (op_r),
    .mode   (mode_r),
    .tim    (tim)
  );

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign mem_addr  = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign mem_we    = mem_we_r;
  assign busy      = (state_r != CFIS_ST_IDLE);
  assign cmd_wr    = dp_valid_r & dp_write_r & (dp_addr_r == cfis_pkg::REG_CTRL);
  assign boundary  = (state_r == CFIS_ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
    end
    else
    begin
      dp_valid_r <= hsel & htrans[1] & hready;
      dp_write_r <= hwrite;
      dp_addr_r  <= haddr[7:0];
    end
  end

  // read data is formed at the address phase, so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0000_0000;
    else if (hsel & htrans[1] & hready & ~hwrite)
      case (haddr[7:0])
        cfis_pkg::REG_CTRL:   hrdata_r <= {3'h0, abs_r, field_r, mode_r, op_r};
        cfis_pkg::REG_STATUS: hrdata_r <= {20'h00000, pend_r, 3'h0, busy, arch_r.sr[3:0]} |
                                          {23'h000000, arch_r.sr[cfis_pkg::SR_G], 8'h00};
        cfis_pkg::REG_PC:     hrdata_r <= {22'h000000, arch_r.pc};
        cfis_pkg::REG_SP:     hrdata_r <= {24'h000000, arch_r.sp};
        cfis_pkg::REG_RESULT: hrdata_r <= {24'h000000, result_r};
        cfis_pkg::REG_ADDR:   hrdata_r <= {20'h00000, ea_r};
        cfis_pkg::REG_TIMING: hrdata_r <= {26'h0000000, tim.legal, tim.bytes, tim.cycles};
        cfis_pkg::REG_INDEX:  hrdata_r <= {20'h00000, index_r};
        default:              hrdata_r <= 32'h0000_0000;
      endcase
    else
      hrdata_r <= 32'h0000_0000;
  end

  // control word: op[3:0], mode[10:4], field[18:11], abs[28:19], bits [31:29] ignored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_r    <= cfis_pkg::CFIS_OP_ALU;
      mode_r  <= cfis_pkg::CFIS_AM_INHERENT;
      field_r <= 8'h00;
      abs_r   <= 10'h000;
      index_r <= 12'h000;
    end
    else if (dp_valid_r & dp_write_r)
    begin
      if (cmd_wr & boundary)
      begin
        op_r    <= cfis_pkg::cfis_op_t'(hwdata[3:0]);
        mode_r  <= cfis_pkg::cfis_mode_t'(hwdata[10:4]);
        field_r <= hwdata[18:11];
        abs_r   <= hwdata[28:19];
      end
      if (dp_addr_r == cfis_pkg::REG_INDEX)
        index_r <= hwdata[11:0];
    end
  end

  // alu operand value comes from the result register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alu_r <= 8'h00;
    else if (dp_valid_r & dp_write_r & (dp_addr_r == cfis_pkg::REG_RESULT))
      alu_r <= hwdata[7:0];
  end

  // stacked bytes kept here too; the core has no read path to data memory
  always_ff @(posedge hclk)
    if (mem_we_r & (mem_addr_r[11:8] == 4'h0))
      stk_r[mem_addr_r[7:0]] <= mem_wdata_r;

  // sources are asynchronous to this clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= irq_src;
      sync2_r <= sync1_r;
    end
  end

  // pending latches; a new event wins over the clear of the one being taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_r <= 4'h0;
    else
      pend_r <= (pend_r & ~((state_r == CFIS_ST_ENTRY && cnt_r == 3'h1) ? grant_r : 4'h0))
                | {sync2_r[3:1], 1'b0}
                | {3'h0, cmd_wr & boundary & (hwdata[3:0] == 4'hA)};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r      <= CFIS_ST_IDLE;
      cnt_r        <= 3'h0;
      grant_r      <= 4'h0;
      vec_r        <= 12'h000;
      soft_r       <= 1'b0;
      set_g_pend_r <= 1'b0;
      ret_pc_r     <= '0;
      arch_r       <= '{pc: cfis_pkg::PC_RESET[PCW_HI:0], sp: cfis_pkg::SP_RESET,
                        sr: 8'h00};
      result_r     <= 8'h00;
      ea_r         <= 12'h000;
      mem_addr_r   <= 12'h000;
      mem_wdata_r  <= 8'h00;
      mem_we_r     <= 1'b0;
    end
    else
    begin
      mem_we_r <= 1'b0;
      case (state_r)
        CFIS_ST_IDLE:
        begin
          if (arb_take)
          begin
            state_r  <= CFIS_ST_ENTRY;
            cnt_r    <= cfis_pkg::ENTRY_CYCLES;
            grant_r  <= arb_grant;
            vec_r    <= arb_vec;
            soft_r   <= arb_grant[cfis_pkg::IRQ_SOFT];
            ret_pc_r <= arch_r.pc;
          end
          else if (cmd_wr)
          begin
            state_r <= CFIS_ST_EXEC;
            cnt_r   <= 3'h1;
          end
        end
        CFIS_ST_EXEC:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h1)
          begin
            case (op_r)
              cfis_pkg::CFIS_OP_ALU, cfis_pkg::CFIS_OP_LOAD:
              begin
                result_r             <= alu_r;
                arch_r.sr[cfis_pkg::SR_Z] <= (alu_r == 8'h00);
                arch_r.sr[cfis_pkg::SR_N] <= alu_r[7];
                case (mode_r)
                  cfis_pkg::CFIS_AM_INDEXED:   ea_r <= index_r + {4'h0, field_r};
                  cfis_pkg::CFIS_AM_INDIRECT:  ea_r <= index_r;
                  cfis_pkg::CFIS_AM_DIRECT:    ea_r <= {4'h0, field_r};
                  cfis_pkg::CFIS_AM_IMMEDIATE: result_r <= field_r;
                  default:                     ea_r <= ea_r;
                endcase
              end
              cfis_pkg::CFIS_OP_STORE:
              begin
                mem_we_r    <= tim.legal;
                mem_wdata_r <= alu_r;
                mem_addr_r  <= (mode_r == cfis_pkg::CFIS_AM_INDEXED) ? index_r + {4'h0, field_r}
                             : (mode_r == cfis_pkg::CFIS_AM_INDIRECT) ? index_r
                             : {4'h0, field_r};
              end
              cfis_pkg::CFIS_OP_FAR_JUMP:
                arch_r.pc <= abs_r;
              cfis_pkg::CFIS_OP_CALL_ABS:
              begin
                ret_pc_r  <= arch_r.pc;
                arch_r.pc <= abs_r;
              end
              cfis_pkg::CFIS_OP_SHORT_BR, cfis_pkg::CFIS_OP_BITMAN:
                arch_r.pc <= arch_r.pc + {2'h0, field_r};
              cfis_pkg::CFIS_OP_SET_G:
                arch_r.sr[cfis_pkg::SR_G] <= 1'b1;
              cfis_pkg::CFIS_OP_SUB_EXIT, cfis_pkg::CFIS_OP_IRQ_EXIT:
              begin
                state_r      <= CFIS_ST_POP;
                cnt_r        <= 3'h1;
                set_g_pend_r <= (op_r == cfis_pkg::CFIS_OP_IRQ_EXIT);
              end
              default:
                cnt_r <= cnt_r + 3'h1;
            endcase
          end
          // call pushes low then high byte on the stack
          if (op_r == cfis_pkg::CFIS_OP_CALL_ABS && cnt_r == 3'h2)
          begin
            mem_we_r    <= 1'b1;
            mem_addr_r  <= {4'h0, arch_r.sp};
            mem_wdata_r <= ret_pc_r[7:0];
          end
          if (op_r == cfis_pkg::CFIS_OP_CALL_ABS && cnt_r == 3'h3)
          begin
            mem_we_r    <= 1'b1;
            mem_addr_r  <= {4'h0, arch_r.sp - 8'h01};
            mem_wdata_r <= {6'h00, ret_pc_r[PCW_HI:8]};
            arch_r.sp   <= arch_r.sp - cfis_pkg::SP_STEP;
          end
          if (cnt_r >= tim.cycles && !(cnt_r == 3'h1 && (op_r == cfis_pkg::CFIS_OP_SUB_EXIT ||
              op_r == cfis_pkg::CFIS_OP_IRQ_EXIT)))
            state_r <= CFIS_ST_IDLE;
        end
        CFIS_ST_ENTRY:
        begin
          cnt_r <= cnt_r - 3'h1;
          case (cnt_r)
            3'h5:
            begin
              mem_we_r    <= 1'b1;
              mem_addr_r  <= {4'h0, arch_r.sp};
              mem_wdata_r <= ret_pc_r[7:0];
            end
            3'h4:
            begin
              mem_we_r    <= 1'b1;
              mem_addr_r  <= {4'h0, arch_r.sp - 8'h01};
              mem_wdata_r <= {6'h00, ret_pc_r[PCW_HI:8]};
              arch_r.sp   <= arch_r.sp - cfis_pkg::SP_STEP;
            end
            3'h3:
              mem_addr_r <= vec_r;
            3'h2:
              arch_r.pc  <= vec_r[PCW_HI:0];
            3'h1:
            begin
              // mask drops only once the pc is stacked and the vector fetched
              if (!soft_r)
                arch_r.sr[cfis_pkg::SR_G] <= 1'b0;
              state_r <= CFIS_ST_IDLE;
            end
            default:
              state_r <= CFIS_ST_IDLE;
          endcase
        end
        CFIS_ST_POP:
        begin
          cnt_r <= cnt_r + 3'h1;
          // pop in reverse order of the push; nested returns need the stack, not a register
          if (cnt_r == 3'h2)
            mem_addr_r <= {4'h0, arch_r.sp + 8'h01};
          if (cnt_r == 3'h2)
            ret_pc_r[PCW_HI:8] <= stk_r[arch_r.sp + 8'h01][1:0];
          if (cnt_r == 3'h3)
            mem_addr_r <= {4'h0, arch_r.sp + cfis_pkg::SP_STEP};
          if (cnt_r == 3'h3)
            ret_pc_r[7:0] <= stk_r[arch_r.sp + cfis_pkg::SP_STEP];
          if (cnt_r == 3'h4)
          begin
            arch_r.sp <= arch_r.sp + cfis_pkg::SP_STEP;
            arch_r.pc <= ret_pc_r;
            if (set_g_pend_r)
              arch_r.sr[cfis_pkg::SR_G] <= 1'b1;
            state_r <= CFIS_ST_IDLE;
          end
        end
        default:
          state_r <= CFIS_ST_IDLE;
      endcase
    end
  end

endmodule : cfis_core

// File: verification/cfis_core_sva.sv
module cfis_core_sva
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        busy
);
  logic [3:0] run_cnt_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // length of the current busy stretch; longest sequence is five cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_cnt_r <= 4'h0;
    else
      run_cnt_r <= busy ? run_cnt_r + 4'h1 : 4'h0;
  end
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("slave response not okay");
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("slave inserted a wait state");
  property p_run; busy |-> run_cnt_r < {1'b0, cfis_pkg::ENTRY_CYCLES}; endproperty
  a_run: assert property (p_run) else $error("sequence longer than five cycles");
  property p_we; mem_we |-> busy || $past(busy); endproperty
  a_we: assert property (p_we) else $error("memory write outside a sequence");
  property p_push; mem_we && $past(mem_we) |-> mem_addr == $past(mem_addr) - 12'h001; endproperty
  a_push: assert property (p_push) else $error("push order wrong");
  property p_rst; $rose(hresetn) |-> !busy && !mem_we; endproperty
  a_rst: assert property (p_rst) else $error("activity right after reset");
  property p_rdata; $rose(hresetn) |-> hrdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not clear after reset");
  property p_unmap;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h1C |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : cfis_core_sva
bind cfis_core cfis_core_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr), .mem_we(mem_we), .busy(busy));

// File: verification/cfis_env_model.sv
module cfis_env_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [2:0]  raise,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  output logic      [3:0]  irq_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [0:4095];
  // peripherals hold their level until software drops it; bit 0 is unused
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_src <= 4'h0;
    else
      irq_src <= {raise, 1'b0};
  end
  always_ff @(posedge hclk)
  begin
    if (mem_we)
      ram[mem_addr] <= mem_wdata;
  end
endmodule : cfis_env_model

// File: verification/tb_cpu_flags_interrupt_sequencer.sv
module tb_cpu_flags_interrupt_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] SP_TOP = {4'h0, cfis_pkg::SP_RESET};
  logic        hclk, hresetn, hsel, hwrite, hready, mem_we, busy, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, raise;
  logic [3:0]  irq_src;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  int          n_mismatch, samples_checked;
  cfis_pkg::cfis_op_t   t_op [8] = '{cfis_pkg::CFIS_OP_LOAD, cfis_pkg::CFIS_OP_LOAD,
    cfis_pkg::CFIS_OP_LOAD, cfis_pkg::CFIS_OP_LOAD, cfis_pkg::CFIS_OP_ALU,
    cfis_pkg::CFIS_OP_ALU, cfis_pkg::CFIS_OP_FAR_JUMP, cfis_pkg::CFIS_OP_CMPX};
  cfis_pkg::cfis_mode_t t_md [8] = '{cfis_pkg::CFIS_AM_INDEXED, cfis_pkg::CFIS_AM_INDIRECT,
    cfis_pkg::CFIS_AM_DIRECT, cfis_pkg::CFIS_AM_IMMEDIATE, cfis_pkg::CFIS_AM_INDIRECT,
    cfis_pkg::CFIS_AM_DIRECT, cfis_pkg::CFIS_AM_ABSOLUTE, cfis_pkg::CFIS_AM_IMMEDIATE};
  logic [7:0] t_rg [8] = '{8'h14, 8'h14, 8'h14, 8'h10, 8'h14, 8'h14, 8'h08, 8'h18};
  logic [9:0] t_ev [8] = '{10'h1F3, 10'h100, 10'h0F3, 10'h0F3, 10'h100, 10'h0F3, 10'h2A5,
    10'h03B};
  logic [5:0] t_tm [8] = '{6'h33, 6'h29, 6'h32, 6'h32, 6'h29, 6'h32, 6'h3C, 6'h3B};
  assign hready = hreadyout;
  cfis_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_src(irq_src),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .busy(busy));
  cfis_env_model env_u (.hclk(hclk), .hresetn(hresetn), .raise(raise),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .irq_src(irq_src));
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  function automatic logic [31:0] cw(cfis_pkg::cfis_op_t o, cfis_pkg::cfis_mode_t m,
    logic [7:0] f, logic [9:0] ab);
    return {3'h0, ab, f, m, o};
  endfunction : cw
  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  // hsel stays high; htrans alone frames each single transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    cmp($sformatf("reg %h", a), rd & m, e);
  endtask : rdc
  // sync delay, a five-cycle exit and an entry chained on it
  task automatic settle;
    repeat (10) @(posedge hclk);
    while (busy !== 1'b0) @(posedge hclk);
  endtask : settle
  task automatic run(input logic [31:0] w);
    ahb(1'b1, cfis_pkg::REG_CTRL, w, rd);
    settle();
  endtask : run
  task automatic op1(input cfis_pkg::cfis_op_t o);
    run(cw(o, cfis_pkg::CFIS_AM_INHERENT, 8'h00, 10'h000));
  endtask : op1
  task automatic pcv(input logic [11:0] v);
    rdc(cfis_pkg::REG_PC, 32'h3FF, {22'h0, v[9:0]});
  endtask : pcv
  task automatic spv(input logic [7:0] v);
    rdc(cfis_pkg::REG_SP, 32'hFF, {24'h0, v});
  endtask : spv
  task automatic gv(input logic g);
    rdc(cfis_pkg::REG_STATUS, 32'h100, {23'h0, g, 8'h0});
  endtask : gv
  // drop the level once entry starts, so it is not taken twice
  task automatic irq(input logic [2:0] v);
    raise <= v;
    @(posedge hclk);
    while (busy !== 1'b1) @(posedge hclk);
    raise <= 3'h0;
    settle();
  endtask : irq
  task automatic back(input cfis_pkg::cfis_op_t o, input logic g);
    op1(o);
    pcv({2'h0, env_u.ram[SP_TOP - 12'h001][1:0], env_u.ram[SP_TOP]});
    spv(cfis_pkg::SP_RESET);
    gv(g);
  endtask : back
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    raise = 3'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    pcv(cfis_pkg::PC_RESET);
    spv(cfis_pkg::SP_RESET);
    gv(1'b0);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
    op1(cfis_pkg::CFIS_OP_SOFT_IRQ);
    pcv(cfis_pkg::VEC_SOFT);
    gv(1'b0);
    spv(cfis_pkg::SP_RESET - cfis_pkg::SP_STEP);
    rdc(cfis_pkg::REG_TIMING, 32'h3F, 32'h2D);
    back(cfis_pkg::CFIS_OP_SUB_EXIT, 1'b0);
    raise <= 3'h2;
    repeat (8) @(posedge hclk);
    cmp("busy", {31'h0, busy}, 32'h0);
    spv(cfis_pkg::SP_RESET);
    raise <= 3'h0;
    op1(cfis_pkg::CFIS_OP_SET_G);
    pcv(cfis_pkg::VEC_WDOG);
    gv(1'b0);
    spv(cfis_pkg::SP_RESET - cfis_pkg::SP_STEP);
    back(cfis_pkg::CFIS_OP_IRQ_EXIT, 1'b1);
    irq(3'h7);
    pcv(cfis_pkg::VEC_WAKE);
    op1(cfis_pkg::CFIS_OP_SET_G);
    pcv(cfis_pkg::VEC_WDOG);
    spv(cfis_pkg::SP_RESET - 8'h04);
    op1(cfis_pkg::CFIS_OP_IRQ_EXIT);
    pcv(cfis_pkg::VEC_MTMR);
    op1(cfis_pkg::CFIS_OP_IRQ_EXIT);
    pcv(cfis_pkg::VEC_WAKE);
    back(cfis_pkg::CFIS_OP_IRQ_EXIT, 1'b1);
    ahb(1'b1, cfis_pkg::REG_INDEX, 32'h100, rd);
    for (int i = 0; i < 8; i++)
    begin
      run(cw(t_op[i], t_md[i], 8'hF3, 10'h2A5));
      rdc(t_rg[i], 32'h3FF, {22'h0, t_ev[i]});
      rdc(cfis_pkg::REG_TIMING, 32'h3F, {26'h0, t_tm[i]});
    end
    for (int k = 0; k < 2; k++)
    begin
      ahb(1'b1, cfis_pkg::REG_RESULT, {24'h0, k[0], 7'h0}, rd);
      run(cw(cfis_pkg::CFIS_OP_ALU, cfis_pkg::CFIS_AM_DIRECT, 8'h00, 10'h000));
      rdc(cfis_pkg::REG_STATUS, 32'hC, {28'h0, k[0], ~k[0], 2'h0});
    end
    run(cw(cfis_pkg::CFIS_OP_SHORT_BR, cfis_pkg::CFIS_AM_RELATIVE, 8'h10, 10'h000));
    pcv(12'h2B5);
    run(cw(cfis_pkg::CFIS_OP_CALL_ABS, cfis_pkg::CFIS_AM_ABSOLUTE, 8'h00, 10'h123));
    pcv(12'h123);
    back(cfis_pkg::CFIS_OP_SUB_EXIT, 1'b1);
    run(cw(cfis_pkg::CFIS_OP_STORE, cfis_pkg::CFIS_AM_IMMEDIATE, 8'hF3, 10'h000));
    rdc(cfis_pkg::REG_TIMING, 32'h20, 32'h0);
    conclude();
  end
endmodule : tb_cpu_flags_interrupt_sequencer
